/* common/pps_pkg.sv */
package pps_pkg;
  localparam int NUM_PINS    = 26;
  localparam int NUM_IN      = 14;
  localparam int NUM_OUTPIN  = 6;
  localparam int SEL_W       = 5;
  localparam int FUNC_SPAN   = 32;
  localparam int NUM_SEL_REG = 12;

  // register word indices, byte address is four times the index
  localparam logic [3:0] IDX_CAPTURE   = 4'h0;
  localparam logic [3:0] IDX_FAULT     = 4'h1;
  localparam logic [3:0] IDX_UART_ONE  = 4'h2;
  localparam logic [3:0] IDX_UART_TWO  = 4'h3;
  localparam logic [3:0] IDX_SPI1_CD   = 4'h4;
  localparam logic [3:0] IDX_SPI1_SEL  = 4'h5;
  localparam logic [3:0] IDX_SPI2_CD   = 4'h6;
  localparam logic [3:0] IDX_SPI2_SEL  = 4'h7;
  localparam logic [3:0] IDX_CAN       = 4'h8;
  localparam logic [3:0] IDX_OUT_FIRST = 4'h9;
  localparam logic [3:0] IDX_LOCK      = 4'hc;
  localparam logic [3:0] IDX_NONE      = 4'hf;

  // field layout
  localparam int FLD_LO_LSB = 0;
  localparam int FLD_HI_LSB = 8;
  localparam int LOCK_BIT   = 0;
  // registers whose upper field exists, one bit per index
  localparam logic [NUM_SEL_REG-1:0] HI_IMPL = 12'he5d;

  // selector codes
  localparam logic [SEL_W-1:0] SEL_LAST_PIN  = 5'h19;
  localparam logic [SEL_W-1:0] SEL_TIED_LOW  = 5'h1f;
  localparam logic [SEL_W-1:0] SEL_NULL_FUNC = 5'h00;

  // peripheral input numbering
  localparam int IN_CAP7   = 0;
  localparam int IN_CAP8   = 1;
  localparam int IN_FAULTA = 2;
  localparam int IN_U1RX   = 3;
  localparam int IN_U1CTS  = 4;
  localparam int IN_U2RX   = 5;
  localparam int IN_U2CTS  = 6;
  localparam int IN_SDI1   = 7;
  localparam int IN_SCK1   = 8;
  localparam int IN_SS1    = 9;
  localparam int IN_SDI2   = 10;
  localparam int IN_SCK2   = 11;
  localparam int IN_SS2    = 12;
  localparam int IN_CANRX  = 13;

  // which register and which half holds each input's selector
  localparam logic [3:0] IN_REG [0:NUM_IN-1] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3,
                                                 4'h4, 4'h4, 4'h5, 4'h6, 4'h6, 4'h7, 4'h8};
  localparam logic       IN_HALF [0:NUM_IN-1] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
                                                  1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  function automatic logic pick_pin(input logic [SEL_W-1:0] sel, input logic [NUM_PINS-1:0] pins);
    if (sel <= SEL_LAST_PIN) begin
      return pins[sel];
    end
    return 1'b0;
  endfunction : pick_pin
endpackage : pps_pkg

/* common/pps_sel_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pps_sel_if;
  logic [pps_pkg::NUM_IN-1:0][pps_pkg::SEL_W-1:0]     inSel;
  logic [pps_pkg::NUM_OUTPIN-1:0][pps_pkg::SEL_W-1:0] outSel;
  logic [pps_pkg::NUM_PINS-1:0]                       pinLvl;
  logic [pps_pkg::FUNC_SPAN-1:0]                      funcLvl;
  logic [pps_pkg::NUM_IN-1:0]                         inRouted;
  logic [pps_pkg::NUM_OUTPIN-1:0]                     outRouted;

  modport ctrl (output inSel, output outSel, output pinLvl, output funcLvl,
                input inRouted, input outRouted);
  modport route (input inSel, input outSel, input pinLvl, input funcLvl,
                 output inRouted, output outRouted);
endinterface : pps_sel_if
`default_nettype wire

/* hdl/pps_route.sv */
`timescale 1ns/10ps
`default_nettype none
module pps_route (
  // selector fields and levels in, routed levels out
  pps_sel_if.route sif
);
  for (genvar k = 0; k < pps_pkg::NUM_IN; k++) begin : g_in
    // codes past the last pin fall into the tied-low case
    assign sif.inRouted[k] = pps_pkg::pick_pin(sif.inSel[k], sif.pinLvl); // [R1]
  end

  for (genvar p = 0; p < pps_pkg::NUM_OUTPIN; p++) begin : g_out
    // the null function gives a low level, and its output enable is off so the pin is released
    assign sif.outRouted[p] = (sif.outSel[p] == pps_pkg::SEL_NULL_FUNC) ? 1'b0 :
                              sif.funcLvl[sif.outSel[p]]; // [R3]
  end
endmodule : pps_route
`default_nettype wire

/* hdl/pps_pin_select.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// [R1] field value picks remappable pin zero to 25
// [R2] all-ones ties input low; fields reset ones
// [R3] output field picks pin function; resets zero
// [R4] up to two fields per word; other bits read zero
// [R5] receive selector disabled without can controller
// [R6] separate uart receive and clear-to-send selectors
// [R7] separate spi clock, data, select selectors
// [R8] capture seven/eight share; fault a separate
// [R9] selector writes only while lock bit clear
// [R10] software still enables peripheral after mapping
// [R11] codes above pin 25 also tie low
module pps_pin_select #(
  parameter bit HAS_CAN  = 1'b1,
  parameter int NUM_FUNC = 32
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // remappable pins
  input  wire logic [pps_pkg::NUM_PINS-1:0]  pinIn,
  output logic      [pps_pkg::NUM_OUTPIN-1:0] pinOut,
  output logic      [pps_pkg::NUM_OUTPIN-1:0] pinOutEn,
  // peripheral side
  input  wire logic [NUM_FUNC-1:0]           funcOut,
  output logic      [pps_pkg::NUM_IN-1:0]    periphIn
);

  typedef struct packed {
    logic                                                  wrPend;
    logic [3:0]                                            wrIdx;
    logic                                                  lock;
    logic [pps_pkg::NUM_SEL_REG-1:0][1:0][pps_pkg::SEL_W-1:0] fld;
    logic [pps_pkg::NUM_PINS-1:0]                          sync1;
    logic [pps_pkg::NUM_PINS-1:0]                          sync2;
    logic [pps_pkg::NUM_PINS-1:0]                          sync3;
    logic [pps_pkg::NUM_PINS-1:0]                          filt;
    logic [pps_pkg::NUM_IN-1:0]                            periph;
    logic [pps_pkg::NUM_OUTPIN-1:0]                        pout;
    logic [pps_pkg::NUM_OUTPIN-1:0]                        poe;
    logic [31:0]                                           rdata;
    logic                                                  ready;
    logic                                                  resp;
  } pps_state_t;

  function automatic pps_state_t reset_state();
    pps_state_t s;
    s = '0;
    s.ready = 1'b1;
    for (int r = 0; r < int'(pps_pkg::IDX_OUT_FIRST); r++) begin
      s.fld[r][0] = pps_pkg::SEL_TIED_LOW; // [R2]
      if (pps_pkg::HI_IMPL[r]) begin
        s.fld[r][1] = pps_pkg::SEL_TIED_LOW; // [R2]
      end
    end
    return s;
  endfunction : reset_state

  localparam pps_state_t RST_ST = reset_state();

  // a selector register that software may reach at all
  function automatic logic sel_present(input logic [3:0] idx);
    return (idx < 4'(pps_pkg::NUM_SEL_REG)) && (HAS_CAN || idx != pps_pkg::IDX_CAN); // [R5]
  endfunction : sel_present

  function automatic logic [31:0] reg_word(input logic [3:0] idx, input pps_state_t s);
    logic [31:0] w;
    w = '0;
    if (idx == pps_pkg::IDX_LOCK) begin
      w[pps_pkg::LOCK_BIT] = s.lock;
    end else if (sel_present(idx)) begin
      w[pps_pkg::FLD_LO_LSB +: pps_pkg::SEL_W] = s.fld[idx][0]; // [R4]
      if (pps_pkg::HI_IMPL[idx]) begin
        w[pps_pkg::FLD_HI_LSB +: pps_pkg::SEL_W] = s.fld[idx][1]; // [R4]
      end
    end
    return w;
  endfunction : reg_word

  pps_state_t st_ff;
  pps_state_t nxt_st;
  logic       accept;
  logic [3:0] addrIdx;

  pps_sel_if sif ();

  pps_route u_route (
    .sif (sif.route)
  );

  // selector fields toward the router
  for (genvar k = 0; k < pps_pkg::NUM_IN; k++) begin : g_in_sel
    // each peripheral input has its own field, none shared
    assign sif.inSel[k] = st_ff.fld[pps_pkg::IN_REG[k]][pps_pkg::IN_HALF[k]]; // [R6] [R7] [R8]
  end
  for (genvar p = 0; p < pps_pkg::NUM_OUTPIN; p++) begin : g_out_sel
    assign sif.outSel[p] = st_ff.fld[int'(pps_pkg::IDX_OUT_FIRST) + p / 2][p % 2]; // [R3]
  end
  // routing uses the filtered pins, never the raw synchroniser stages
  assign sif.pinLvl  = st_ff.filt;
  assign sif.funcLvl = pps_pkg::FUNC_SPAN'(funcOut);

  assign accept  = hsel && htrans[1] && hready;
  assign addrIdx = (haddr[31:6] == 26'h0 && haddr[5:2] <= pps_pkg::IDX_LOCK) ? haddr[5:2] :
                   pps_pkg::IDX_NONE;

  always_comb begin
    nxt_st = st_ff;
    // three-stage pin synchroniser, a level counts once stages two and three agree
    nxt_st.sync1 = pinIn;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int i = 0; i < pps_pkg::NUM_PINS; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.filt[i] = st_ff.sync2[i];
      end
    end
    // data phase of a write taken last cycle
    if (st_ff.wrPend) begin
      if (st_ff.wrIdx == pps_pkg::IDX_LOCK) begin
        nxt_st.lock = hwdata[pps_pkg::LOCK_BIT];
      end else if (!st_ff.lock && sel_present(st_ff.wrIdx)) begin // [R9] [R5]
        nxt_st.fld[st_ff.wrIdx][0] = hwdata[pps_pkg::FLD_LO_LSB +: pps_pkg::SEL_W];
        if (pps_pkg::HI_IMPL[st_ff.wrIdx]) begin
          nxt_st.fld[st_ff.wrIdx][1] = hwdata[pps_pkg::FLD_HI_LSB +: pps_pkg::SEL_W]; // [R4]
        end
      end
    end
    // address phase; every transfer is zero wait state and okay
    nxt_st.wrPend = accept && hwrite;
    nxt_st.wrIdx  = addrIdx;
    nxt_st.rdata  = '0;
    if (accept && !hwrite) begin
      // read through the pending write so back-to-back access sees new data
      nxt_st.rdata = reg_word(addrIdx, nxt_st);
    end
    nxt_st.ready = 1'b1;
    nxt_st.resp  = 1'b0;
    // routed levels registered so every output leaves a flop
    nxt_st.periph = sif.inRouted; // [R1] [R2] [R11]
    nxt_st.pout   = sif.outRouted;
    for (int p = 0; p < pps_pkg::NUM_OUTPIN; p++) begin
      nxt_st.poe[p] = (sif.outSel[p] != pps_pkg::SEL_NULL_FUNC); // [R3]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata    = st_ff.rdata;
  assign hreadyout = st_ff.ready;
  assign hresp     = st_ff.resp;
  assign pinOut    = st_ff.pout;
  assign pinOutEn  = st_ff.poe;
  assign periphIn  = st_ff.periph;

  // helpers read only by assertions
  logic [pps_pkg::SEL_W-1:0] u1rxSel;
  logic                      u1rxExpect;
  logic                      agree0;
  logic                      pin0Expect;
  logic                      fldWrite;
  logic [pps_pkg::SEL_W-1:0] u1rxWritten;
  assign u1rxSel     = st_ff.fld[pps_pkg::IDX_UART_ONE][0];
  assign u1rxExpect  = (u1rxSel <= pps_pkg::SEL_LAST_PIN) ? st_ff.filt[u1rxSel] : 1'b0;
  assign agree0      = (st_ff.sync2[0] == st_ff.sync3[0]);
  assign pin0Expect  = sif.funcLvl[st_ff.fld[pps_pkg::IDX_OUT_FIRST][0]];
  assign fldWrite    = st_ff.wrPend && st_ff.wrIdx == pps_pkg::IDX_UART_ONE && !st_ff.lock;
  assign u1rxWritten = hwdata[pps_pkg::FLD_LO_LSB +: pps_pkg::SEL_W];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  route_pin_a : assert property ( // [R1]
    (u1rxSel <= pps_pkg::SEL_LAST_PIN) |=> (periphIn[pps_pkg::IN_U1RX] == $past(u1rxExpect)))
    else $error("uart one receive not routed from selected pin");

  sync_agree_a : assert property ( // [R1]
    (st_ff.filt[0] != $past(st_ff.filt[0])) |-> $past(agree0))
    else $error("filtered pin changed without stage agreement");

  reset_low_a : assert property ( // [R2]
    $past(rst) |-> (periphIn == '0 && u1rxSel == pps_pkg::SEL_TIED_LOW))
    else $error("inputs not tied low after reset");

  high_code_a : assert property ( // [R11]
    (u1rxSel > pps_pkg::SEL_LAST_PIN) [*2] |-> (periphIn[pps_pkg::IN_U1RX] == 1'b0))
    else $error("code past last pin did not tie input low");

  ss2_low_a : assert property ( // [R11]
    (st_ff.fld[pps_pkg::IDX_SPI2_SEL][0] > pps_pkg::SEL_LAST_PIN) |=> !periphIn[pps_pkg::IN_SS2])
    else $error("spi two select not tied low");

  out_reset_a : assert property ( // [R3]
    $past(rst) |-> (pinOutEn == '0 && pinOut == '0))
    else $error("output pins not idle after reset");

  out_drive_a : assert property ( // [R3]
    (st_ff.fld[pps_pkg::IDX_OUT_FIRST][0] != pps_pkg::SEL_NULL_FUNC)
      |=> (pinOutEn[0] && pinOut[0] == $past(pin0Expect)))
    else $error("pin zero not driven by selected function");

  unused_zero_a : assert property ( // [R4]
    $past(accept && !hwrite && addrIdx == pps_pkg::IDX_FAULT)
      |-> (hrdata[31:5] == 27'h0))
    else $error("unimplemented bits read nonzero");

  can_off_a : assert property ( // [R5]
    !HAS_CAN |-> (periphIn[pps_pkg::IN_CANRX] == 1'b0))
    else $error("can receive routed on variant without can");

  lock_hold_a : assert property ( // [R9]
    (st_ff.wrPend && st_ff.lock && st_ff.wrIdx != pps_pkg::IDX_LOCK) |=> $stable(st_ff.fld))
    else $error("selector changed while locked");

  unlock_write_a : assert property ( // [R9]
    fldWrite |=> (u1rxSel == $past(u1rxWritten)))
    else $error("unlocked selector write lost");

endmodule : pps_pin_select
`default_nettype wire

/* dv/pps_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pps_far_model (
  // clock
  input  wire logic                         clk,
  // wanted levels from the bench
  input  wire logic [pps_pkg::NUM_PINS-1:0] pinPat,
  input  wire logic [31:0]                  funcPat,
  input  wire logic                         funcEn,
  // levels toward the block
  output logic      [pps_pkg::NUM_PINS-1:0] pinIn,
  output logic      [31:0]                  funcOut
);
  always_ff @(posedge clk) begin
    pinIn <= pinPat;
    // mapping alone does not start a peripheral; disabled ones keep outputs low
    funcOut <= funcEn ? {funcPat[31:1], 1'b0} : 32'h0000_0000;
  end
endmodule : pps_far_model
`default_nettype wire

/* dv/pps_pin_select_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pps_pin_select_tb;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, funcEn;
  logic [31:0] haddr, hwdata, hrdata, funcPat, funcOut, dummy;
  logic [1:0]  htrans;
  logic [25:0] pinPat, pinIn;
  logic [5:0]  pinOut, pinOutEn;
  logic [13:0] periphIn;
  int          mismatches, checks_done;

  pps_pin_select dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn), .pinOut(pinOut),
    .pinOutEn(pinOutEn), .funcOut(funcOut), .periphIn(periphIn));
  pps_far_model far_u (.clk(clk), .pinPat(pinPat), .funcPat(funcPat), .funcEn(funcEn),
    .pinIn(pinIn), .funcOut(funcOut));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one single transfer; waits on hready in both phases, only the watchdog ends a wait
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {26'h0, idx, 2'h0};
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, idx, 32'h0000_0000, got);
    check(got, exp, "register read");
    check({31'h0, hresp}, 32'h0, "response");
  endtask : rdchk

  function automatic logic [31:0] fmask(input int i);
    return pps_pkg::HI_IMPL[i] ? 32'h0000_1f1f : 32'h0000_001f;
  endfunction : fmask

  task automatic t_reset;
    for (int i = 0; i < 13; i++) begin
      rdchk(4'(i), (i < 9) ? fmask(i) : 32'h0000_0000);
    end
    rdchk(4'hd, 32'h0000_0000);
    check({18'h0, periphIn}, 32'h0, "inputs tied low");
    check({26'h0, pinOutEn}, 32'h0, "pins released");
    check({26'h0, pinOut}, 32'h0, "pins low");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pack;
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, 4'(i), 32'hffff_ffff, dummy);
      rdchk(4'(i), fmask(i));
    end
    bus(1'b1, 4'hd, 32'hffff_ffff, dummy);
    rdchk(4'hd, 32'h0000_0000);
    $display("test packing done");
  endtask : t_pack

  task automatic t_route;
    logic [4:0]  codes [4] = '{5'h00, 5'h19, 5'h1a, 5'h1f};
    logic [4:0]  c;
    logic [25:0] hot;
    for (int k = 0; k < pps_pkg::NUM_IN; k++) begin
      for (int j = 0; j < 4; j++) begin
        c = codes[j];
        hot = (c <= 5'h19) ? (26'h1 << c) : 26'h3ff_ffff;
        // the other field of the word stays tied low so only input k can follow the pins
        bus(1'b1, pps_pkg::IN_REG[k], pps_pkg::IN_HALF[k] ? {19'h0, c, 8'h1f} : {19'h0, 5'h1f, 3'h0, c},
            dummy);
        pinPat <= hot;
        repeat (8) @(posedge clk);
        check({18'h0, periphIn}, (c <= 5'h19) ? (32'h1 << k) : 32'h0, "routed high");
        pinPat <= ~hot;
        repeat (8) @(posedge clk);
        check({18'h0, periphIn}, 32'h0, "routed low");
      end
    end
    $display("test routing done");
  endtask : t_route

  task automatic t_out;
    logic [4:0] c;
    // packing left every pin on code 1f; start from null functions
    for (int r = 9; r < 12; r++) begin
      bus(1'b1, 4'(r), 32'h0000_0000, dummy);
    end
    repeat (4) @(posedge clk);
    check({26'h0, pinOutEn}, 32'h0, "null functions");
    for (int j = 0; j < 6; j++) begin
      for (int m = 0; m < 2; m++) begin
        c = m ? 5'h1f : 5'h01;
        bus(1'b1, 4'(9 + j / 2), (j % 2) ? {19'h0, c, 8'h00} : {27'h0, c}, dummy);
        funcEn <= 1'b1;
        funcPat <= 32'h1 << c;
        repeat (4) @(posedge clk);
        check({20'h0, pinOut, pinOutEn}, {20'h0, 6'h1 << j, 6'h1 << j}, "function high");
        funcPat <= ~(32'h1 << c);
        repeat (4) @(posedge clk);
        check({20'h0, pinOut, pinOutEn}, {20'h0, 6'h0, 6'h1 << j}, "function low");
      end
      funcPat <= 32'hffff_ffff;
      funcEn <= 1'b0;
      repeat (4) @(posedge clk);
      check({26'h0, pinOut}, 32'h0, "disabled peripheral");
      bus(1'b1, 4'(9 + j / 2), 32'h0000_0000, dummy);
      repeat (4) @(posedge clk);
      check({26'h0, pinOutEn}, 32'h0, "null function");
    end
    $display("test outputs done");
  endtask : t_out

  task automatic t_lock;
    bus(1'b1, 4'hc, 32'h0000_0001, dummy);
    rdchk(4'hc, 32'h0000_0001);
    bus(1'b1, 4'h0, 32'h0000_0000, dummy);
    rdchk(4'h0, 32'h0000_1f1f);
    bus(1'b1, 4'h9, 32'h0000_1f1f, dummy);
    rdchk(4'h9, 32'h0000_0000);
    bus(1'b1, 4'hc, 32'h0000_0000, dummy);
    bus(1'b1, 4'h0, 32'h0000_0000, dummy);
    rdchk(4'h0, 32'h0000_0000);
    $display("test lock done");
  endtask : t_lock

  // whole run needs roughly 1400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    pinPat = 26'h0;
    funcPat = 32'h0000_0000;
    funcEn = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pack();
    t_route();
    t_out();
    t_lock();
    close_out();
  end
endmodule : pps_pin_select_tb
`default_nettype wire
